// File: rtl/gbau_core.sv
// Gyro bias correction and alarm unit: register file, offset summing,
// automatic bias correction, factory restore and two alarms.
// Assumes the serial front end and sample chain share core_clk.
`timescale 1ns/1ps
`include "gbau_params.svh"
module gbau_core
  import gbau_pkg::*;
#(
  parameter int unsigned FLASH_CYC = `GBAU_FLASH_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  input  wire logic        sample,
  input  wire logic [31:0] gyro_raw,
  input  wire logic [15:0] gyro_filt_upper,
  input  wire logic [15:0] temp_word,
  input  wire logic [4:0]  decimation_setting,
  output logic             data_ready,
  output logic             dec_restart,
  output logic             nvm_commit,
  output logic             abc_busy,
  output logic             general_line_one_out,
  output logic             general_line_one_oe,
  output logic             general_line_two_out,
  output logic             general_line_two_oe
);
  // ==========================================================
  // Register state.
  logic [15:0] gyro_bias_fine_q;
  logic [15:0] gyro_bias_coarse_q;
  logic [15:0] alarm_one_threshold_q;
  logic [15:0] alarm_two_threshold_q;
  logic [15:0] alarm_one_sample_period_q;
  logic [15:0] alarm_two_sample_period_q;
  logic [15:0] alarm_configuration_q;
  logic [1:0]  gcmd_q;
  logic [31:0] rate_q;
  logic [1:0]  alm_flag;
  logic [16:0] dec_cnt_q;
  gbau_state_t state_q;
  gbau_state_t state_d;
  logic        flash_load;
  logic        flash_done;
  logic        restore_q;
  // ==========================================================
  // Decode; writes are refused while the routine runs, reads too except while restore_q is set.
  logic        bus_open;
  logic        wr_ok;
  logic        rd_ok;
  logic        wr_bias_f;
  logic        wr_bias_c;
  logic        wr_thr1;
  logic        wr_thr2;
  logic        wr_per1;
  logic        wr_per2;
  logic        wr_cfg;
  logic        wr_gcmd;
  assign bus_open  = (state_q == GBAU_IDLE) || restore_q;
  assign wr_ok     = reg_wr && (state_q == GBAU_IDLE);
  assign rd_ok     = reg_rd && bus_open;
  assign wr_bias_f = wr_ok && (reg_addr == `GBAU_ADDR_BIAS_FINE);
  assign wr_bias_c = wr_ok && (reg_addr == `GBAU_ADDR_BIAS_CRS);
  assign wr_thr1   = wr_ok && (reg_addr == `GBAU_ADDR_THR1);
  assign wr_thr2   = wr_ok && (reg_addr == `GBAU_ADDR_THR2);
  assign wr_per1   = wr_ok && (reg_addr == `GBAU_ADDR_PER1);
  assign wr_per2   = wr_ok && (reg_addr == `GBAU_ADDR_PER2);
  assign wr_cfg    = wr_ok && (reg_addr == `GBAU_ADDR_ALM_CFG);
  assign wr_gcmd   = wr_ok && (reg_addr == `GBAU_ADDR_GCMD);
  // ==========================================================
  // Command starts; restore wins if both bits are written at once.
  logic        start_restore;
  logic        start_abc;
  assign start_restore = wr_gcmd && reg_wdata[`GBAU_GCMD_RESTORE];
  assign start_abc     = wr_gcmd && reg_wdata[`GBAU_GCMD_ABC] &&
                         !reg_wdata[`GBAU_GCMD_RESTORE];
  // ==========================================================
  // Decimation counter: 2^D samples per output cycle, D capped.
  logic [4:0]  dec_sel;
  logic [16:0] dec_last;
  logic        dec_end;
  assign dec_sel  = (decimation_setting > `GBAU_DEC_MAX) ?
                    `GBAU_DEC_MAX : decimation_setting;
  assign dec_last = 17'((17'h0_0001 << dec_sel) - 17'h0_0001);
  assign dec_end  = sample && (dec_cnt_q == dec_last);
  // The count restarts the cycle after the arming wait ends, so the averaged
  // cycle that follows is always a full one, never a partial one.
  always_ff @(posedge core_clk) begin
    if (!nrst || dec_restart)
      dec_cnt_q <= 17'h0_0000;
    else if (dec_end)
      dec_cnt_q <= 17'h0_0000;
    else if (sample)
      dec_cnt_q <= dec_cnt_q + 17'h0_0001;
  end
  // ==========================================================
  // Corrected output: coarse pairs with the upper rate word, fine
  // with the lower, summed as one 32-bit two's complement value.
  logic [31:0] bias;
  logic [31:0] rate_sum;
  assign bias     = {gyro_bias_coarse_q, gyro_bias_fine_q};
  assign rate_sum = gyro_raw + bias;
  // The sum wraps like a plain adder; a bias that pushes the rate
  // past full scale is a limitation the host must keep in mind.
  always_ff @(posedge core_clk) begin
    if (!nrst || restore_q)
      rate_q <= 32'h0000_0000;
    else if (sample)
      rate_q <= rate_sum;
  end
  // ==========================================================
  // Sequencer for automatic correction and commit.
  always_comb begin
    state_d = state_q;
    case (state_q)
      GBAU_IDLE: begin
        if (start_restore)
          state_d = GBAU_FLASH;
        else if (start_abc)
          state_d = GBAU_ARM;
      end
      GBAU_ARM: begin
        if (dec_end)
          state_d = GBAU_AVG;
      end
      GBAU_AVG: begin
        if (dec_end)
          state_d = GBAU_STORE;
      end
      GBAU_STORE: state_d = GBAU_FLASH;
      GBAU_FLASH: begin
        if (flash_done)
          state_d = GBAU_IDLE;
      end
      default: state_d = GBAU_IDLE;
    endcase
  end
  assign flash_load = (state_q != GBAU_FLASH) &&
                      (state_d == GBAU_FLASH);
  // State register; only the reset pin can leave a running routine.
  always_ff @(posedge core_clk) begin
    if (!nrst)
      state_q <= GBAU_IDLE;
    else
      state_q <= state_d;
  end
  // ==========================================================
  // Command bits are held in gcmd_q as busy flags until their work is done; they do not read back.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      gcmd_q    <= 2'b00;
      restore_q <= 1'b0;
    end else begin
      restore_q <= start_restore;
      if (start_restore)
        gcmd_q <= 2'b10;
      else if (start_abc)
        gcmd_q <= 2'b01;
      else if (flash_done)
        gcmd_q <= 2'b00;
    end
  end
  // One shared countdown stands for the nonvolatile commit time of
  // both the correction and the restore.
  gbau_timer #(
    .CYCLES (FLASH_CYC)
  ) u_flash_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (flash_load),
    .done     (flash_done)
  );
  // ==========================================================
  // User registers. Restore zeroes all calibration registers; the
  // correction stores the negated reading that the host would read.
  logic [31:0] neg_rate;
  assign neg_rate = 32'h0000_0000 - rate_q;
  // The store outranks host writes; the bus refuses them in that
  // state anyway, so no accepted write is ever lost.
  always_ff @(posedge core_clk) begin
    if (!nrst || restore_q) begin
      gyro_bias_fine_q          <= 16'h0000;
      gyro_bias_coarse_q        <= 16'h0000;
      alarm_one_threshold_q     <= 16'h0000;
      alarm_two_threshold_q     <= 16'h0000;
      alarm_one_sample_period_q <= 16'h0000;
      alarm_two_sample_period_q <= 16'h0000;
      alarm_configuration_q     <= `GBAU_CFG_RESET;
    end else if (state_q == GBAU_STORE) begin
      gyro_bias_coarse_q <= neg_rate[31:16];
      gyro_bias_fine_q   <= neg_rate[15:0];
    end else begin
      if (wr_bias_f)
        gyro_bias_fine_q <= reg_wdata;
      if (wr_bias_c)
        gyro_bias_coarse_q <= reg_wdata;
      if (wr_thr1)
        alarm_one_threshold_q <= reg_wdata;
      if (wr_thr2)
        alarm_two_threshold_q <= reg_wdata;
      if (wr_per1)
        alarm_one_sample_period_q <= reg_wdata;
      if (wr_per2)
        alarm_two_sample_period_q <= reg_wdata;
      if (wr_cfg)
        alarm_configuration_q <= reg_wdata;
    end
  end
  // ==========================================================
  // Alarm channels, one instance each, sharing the source bundle.
  logic [15:0]   status_word;
  gbau_src_t     src;
  gbau_alm_cfg_t alm_cfg [0:1];
  logic [15:0]   alm_thr [0:1];
  logic [7:0]    alm_per [0:1];
  assign status_word = {6'h00, alm_flag, 8'h00};
  assign src = '{gyro: rate_q[31:16], gyro_filt: gyro_filt_upper,
                 temp: temp_word, status: status_word};
  assign alm_thr[0] = alarm_one_threshold_q;
  assign alm_thr[1] = alarm_two_threshold_q;
  assign alm_per[0] = alarm_one_sample_period_q[7:0];
  assign alm_per[1] = alarm_two_sample_period_q[7:0];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_alm
      assign alm_cfg[gi] = '{
        src:  alarm_configuration_q[8 + 4*gi +: 4],
        roc:  alarm_configuration_q[6 + gi],
        pol:  alarm_configuration_q[4 + gi],
        filt: alarm_configuration_q[`GBAU_CFG_FILT]};
      gbau_alarm u_alarm (
        .core_clk (core_clk),
        .nrst     (nrst),
        .sample   (sample),
        .clr      (restore_q),
        .cfg      (alm_cfg[gi]),
        .src      (src),
        .thr      (alm_thr[gi]),
        .period   (alm_per[gi]),
        .flag     (alm_flag[gi])
      );
    end
  endgenerate
  // ==========================================================
  // Alarm indicator pin: only the selected line is driven.
  logic alm_any;
  logic alm_lvl;
  logic pin_en;
  logic pin_sel;
  assign alm_any = |alm_flag;
  assign pin_en  = alarm_configuration_q[`GBAU_CFG_PIN_EN];
  assign pin_sel = alarm_configuration_q[`GBAU_CFG_PIN_SEL];
  assign alm_lvl = alarm_configuration_q[`GBAU_CFG_PIN_POL] ?
                   alm_any : !alm_any;
  // Both levels follow the alarm and only the enables pick a line,
  // so moving the indicator between lines never glitches its level.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      general_line_one_out <= 1'b0;
      general_line_one_oe  <= 1'b0;
      general_line_two_out <= 1'b0;
      general_line_two_oe  <= 1'b0;
    end else begin
      general_line_one_out <= alm_lvl;
      general_line_one_oe  <= pin_en && !pin_sel;
      general_line_two_out <= alm_lvl;
      general_line_two_oe  <= pin_en && pin_sel;
    end
  end
  // ==========================================================
  // Strobes and status outputs, all registered.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      data_ready  <= 1'b0;
      dec_restart <= 1'b0;
      nvm_commit  <= 1'b0;
      abc_busy    <= 1'b0;
    end else begin
      data_ready  <= dec_end;
      dec_restart <= (state_q == GBAU_ARM) && dec_end;
      nvm_commit  <= flash_load;
      abc_busy    <= (state_d != GBAU_IDLE) && !restore_q &&
                     !start_restore && (gcmd_q != 2'b10);
    end
  end
  // ==========================================================
  // Read mux; unmapped and write-only addresses return zero.
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `GBAU_ADDR_TEMP:      rd_mux = temp_word;
      `GBAU_ADDR_RATE_LO:   rd_mux = rate_q[15:0];
      `GBAU_ADDR_RATE_UP:   rd_mux = rate_q[31:16];
      `GBAU_ADDR_BIAS_FINE: rd_mux = gyro_bias_fine_q;
      `GBAU_ADDR_BIAS_CRS:  rd_mux = gyro_bias_coarse_q;
      `GBAU_ADDR_THR1:      rd_mux = alarm_one_threshold_q;
      `GBAU_ADDR_THR2:      rd_mux = alarm_two_threshold_q;
      `GBAU_ADDR_PER1:      rd_mux = alarm_one_sample_period_q;
      `GBAU_ADDR_PER2:      rd_mux = alarm_two_sample_period_q;
      `GBAU_ADDR_ALM_CFG:   rd_mux = alarm_configuration_q;
      `GBAU_ADDR_STATUS:    rd_mux = status_word;
      default:              rd_mux = 16'h0000;
    endcase
  end
  // A refused read leaves the last answer standing on reg_rdata.
  always_ff @(posedge core_clk) begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else if (rd_ok)
      reg_rdata <= rd_mux;
  end
endmodule // gbau_core

// File: rtl/gbau_params.svh
// Constants of the gyro bias and alarm unit: offsets, fields, timing.
// Assumes a 200 MHz core_clk; included by the package and gbau_core.
`ifndef GBAU_PARAMS_SVH
`define GBAU_PARAMS_SVH
`define GBAU_ADDR_TEMP      7'h02
`define GBAU_ADDR_RATE_LO   7'h04
`define GBAU_ADDR_RATE_UP   7'h06
`define GBAU_ADDR_BIAS_FINE 7'h08
`define GBAU_ADDR_BIAS_CRS  7'h0a
`define GBAU_ADDR_THR1      7'h10
`define GBAU_ADDR_THR2      7'h12
`define GBAU_ADDR_PER1      7'h14
`define GBAU_ADDR_PER2      7'h16
`define GBAU_ADDR_ALM_CFG   7'h18
`define GBAU_ADDR_STATUS    7'h26
`define GBAU_ADDR_GCMD      7'h28
`define GBAU_GCMD_ABC       0
`define GBAU_GCMD_RESTORE   1
`define GBAU_STAT_ALM_LSB   8
`define GBAU_CFG_FILT       3
`define GBAU_CFG_PIN_EN     2
`define GBAU_CFG_PIN_POL    1
`define GBAU_CFG_PIN_SEL    0
`define GBAU_CFG_RESET      16'h0000
`define GBAU_SRC_OFF        4'h0
`define GBAU_SRC_GYRO       4'h1
`define GBAU_SRC_TEMP       4'h2
`define GBAU_SRC_STATUS     4'h3
`define GBAU_DEC_MAX        5'h10
`define GBAU_CLK_MHZ        200
`define GBAU_FLASH_MS       72
`define GBAU_FLASH_CYC      (`GBAU_FLASH_MS * 1000 * `GBAU_CLK_MHZ)
`endif

// File: rtl/gbau_pkg.sv
// Types shared by the gyro bias and alarm unit modules.
// Assumes gbau_params.svh is on the include path.
`include "gbau_params.svh"
package gbau_pkg;
  typedef struct packed {
    logic [3:0] src;
    logic       roc;
    logic       pol;
    logic       filt;
  } gbau_alm_cfg_t;
  typedef struct packed {
    logic [15:0] gyro;
    logic [15:0] gyro_filt;
    logic [15:0] temp;
    logic [15:0] status;
  } gbau_src_t;
  typedef enum logic [2:0] {
    GBAU_IDLE  = 3'b000,
    GBAU_ARM   = 3'b001,
    GBAU_AVG   = 3'b010,
    GBAU_STORE = 3'b011,
    GBAU_FLASH = 3'b100
  } gbau_state_t;
endpackage

// File: rtl/gbau_timer.sv
// Countdown used for nonvolatile commit time.
// Assumes a one-cycle load pulse on the same clock.
`timescale 1ns/1ps
module gbau_timer #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic load,
  output logic      done
);
  logic [31:0] cnt_q;
  // ==========================================================
  // Count down; done pulses on the cycle after the count reads one, as it reaches zero.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q <= 32'h0000_0000;
      done  <= 1'b0;
    end else begin
      done <= (cnt_q == 32'h0000_0001);
      if (load)
        cnt_q <= 32'(CYCLES);
      else if (cnt_q != 32'h0000_0000)
        cnt_q <= cnt_q - 32'h0000_0001;
    end
  end
endmodule // gbau_timer

// File: rtl/gbau_alarm.sv
// One alarm channel: static or rate-of-change comparison per sample.
// Assumes a one-cycle sample strobe and same-clock configuration.
`timescale 1ns/1ps
module gbau_alarm
  import gbau_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                sample,
  input  wire logic                clr,
  input  wire gbau_pkg::gbau_alm_cfg_t cfg,
  input  wire gbau_pkg::gbau_src_t src,
  input  wire logic [15:0]         thr,
  input  wire logic [7:0]          period,
  output logic                     flag
);
  logic [15:0] hist_q [0:255];
  logic [7:0]  ptr_q;
  logic [15:0] cur;
  logic [15:0] old;
  logic [7:0]  lag;
  logic [16:0] diff;
  logic [15:0] mag;
  logic        is_signed;
  logic        above;
  logic        below;
  // ==========================================================
  // Source pick; filtering only touches the gyro source.
  assign cur = (cfg.src == `GBAU_SRC_GYRO) ?
               (cfg.filt ? src.gyro_filt : src.gyro) :
               (cfg.src == `GBAU_SRC_TEMP) ? src.temp :
               src.status;
  assign lag = (period < 8'h02) ? 8'h01 : period;
  assign old = hist_q[8'(ptr_q - lag)];
  assign diff = {cur[15], cur} - {old[15], old};
  assign mag = diff[16] ? 16'(-diff) : diff[15:0];
  assign is_signed = (cfg.src != `GBAU_SRC_STATUS);
  // Rate mode compares an unsigned magnitude against the threshold.
  assign above = cfg.roc ? (mag > thr) :
                 is_signed ? ($signed(cur) > $signed(thr)) :
                 (cur > thr);
  assign below = cfg.roc ? (mag < thr) :
                 is_signed ? ($signed(cur) < $signed(thr)) :
                 (cur < thr);
  // ==========================================================
  // History ring, one entry per sample, indexed by write pointer.
  always_ff @(posedge core_clk) begin
    if (sample)
      hist_q[ptr_q] <= cur;
  end
  // ==========================================================
  // Evaluate once per sample; a disabled source holds the flag low.
  always_ff @(posedge core_clk) begin
    if (!nrst || clr) begin
      ptr_q <= 8'h00;
      flag  <= 1'b0;
    end else if (sample) begin
      ptr_q <= ptr_q + 8'h01;
      flag  <= (cfg.src != `GBAU_SRC_OFF) &&
               (cfg.pol ? above : below);
    end
  end
endmodule // gbau_alarm

// File: bench/gbau_host.sv
// Host model: drives the register strobes and the sample strobe.
// Assumes the core takes requests on the rising edge of core_clk.
`timescale 1ns/1ps
module gbau_host (
  input  wire logic        core_clk,
  input  wire logic [15:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [6:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             sample
);
  // ==========================================================
  // Bus cycles
  // Everything idles low at time zero so no request precedes reset.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    sample = 1'b0;
  end
  // Commands reach the core only through this write cycle.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // A released bus must not look like the last word.
  endtask
  // Read data is taken just after the edge that samples the strobe.
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // One internal sample strobe, one cycle wide.
  task automatic smp();
    @(posedge core_clk);
    #1;
    sample = 1'b1;
    @(posedge core_clk);
    #1;
    sample = 1'b0;
  endtask
endmodule // gbau_host

// File: bench/gbau_core_props.sv
// Checker for the gyro bias and alarm unit, bound to gbau_core.
// Assumes one clock domain, core_clk, with synchronous nrst.
`timescale 1ns/1ps
module gbau_core_props #(
  parameter int unsigned FLASH_CYC = 20
) (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [6:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        dec_restart,
  input wire logic        nvm_commit,
  input wire logic        abc_busy,
  input wire logic        general_line_one_oe,
  input wire logic        general_line_two_oe
);
  import gbau_pkg::*;
  // ==========================================================
  // Helpers
  logic [31:0] hold_q;
  // A write only counts while neither routine runs.
  wire wr_ok = reg_wr && !abc_busy && (hold_q == 32'h0000_0000);
  wire wr_cmd = wr_ok && (reg_addr == 7'h28);
  // Writes are refused for the whole restore, commit included, so
  // this count covers the restore and its commit time.
  always_ff @(posedge core_clk) begin
    if (!nrst)
      hold_q <= 32'h0000_0000;
    else if (wr_cmd && reg_wdata[1])
      hold_q <= 32'(FLASH_CYC + 1);
    else if (hold_q != 32'h0000_0000)
      hold_q <= hold_q - 32'h0000_0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Properties
  AST_GCMD_START: assert property (
    wr_cmd && reg_wdata[1:0] == 2'b01 |=> abc_busy)
    else $error("correction did not start after command");
  AST_RESTORE_COMMIT: assert property (
    wr_cmd && reg_wdata[1] |=> nvm_commit)
    else $error("restore did not commit on the next cycle");
  AST_COMMIT_PULSE: assert property (
    nvm_commit |=> !nvm_commit)
    else $error("commit strobe longer than one cycle");
  AST_READ_FROZEN: assert property (
    abc_busy && reg_rd |=> $stable(reg_rdata))
    else $error("read answered while correction runs");
  AST_RESTART_BUSY: assert property (
    dec_restart |-> abc_busy)
    else $error("decimation restart outside correction");
  AST_COMMIT_HOLD: assert property (
    nvm_commit && abc_busy |=> abc_busy [*8])
    else $error("correction ended before commit finished");
  AST_PIN_EXCL: assert property (
    !(general_line_one_oe && general_line_two_oe))
    else $error("both general lines driven");
  AST_PIN_OFF: assert property (
    wr_ok && reg_addr == 7'h18 && !reg_wdata[2] |->
      ##3 !(general_line_one_oe || general_line_two_oe))
    else $error("alarm pin driven while disabled");
  AST_GCMD_READ_ZERO: assert property (
    reg_rd && !abc_busy && reg_addr == 7'h28 |=> reg_rdata == 16'h0000)
    else $error("command register did not read zero");
endmodule // gbau_core_props
bind gbau_core gbau_core_props #(.FLASH_CYC(FLASH_CYC)) u_props (
  .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .dec_restart(dec_restart), .nvm_commit(nvm_commit),
  .abc_busy(abc_busy), .general_line_one_oe(general_line_one_oe),
  .general_line_two_oe(general_line_two_oe));

// File: bench/testbench.sv
// Self-checking bench for gbau_core with a host model.
// Assumes a short nonvolatile commit time set through FLASH_CYC.
`timescale 1ns/1ps
module testbench;
  import gbau_pkg::*;
  logic        core_clk, nrst, reg_wr, reg_rd, sample;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, gyro_filt_upper, temp_word, d;
  logic [31:0] gyro_raw, e;
  logic [4:0]  decimation_setting;
  logic        data_ready, dec_restart, nvm_commit, abc_busy;
  logic        l1o, l1e, l2o, l2e;
  int          errors, samples_checked, commits, readies;
  wire [3:0]   pins = {l1o, l1e, l2o, l2e};
  gbau_core #(.FLASH_CYC(20)) dut (
    .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample(sample), .gyro_raw(gyro_raw), .gyro_filt_upper(gyro_filt_upper),
    .temp_word(temp_word), .decimation_setting(decimation_setting),
    .data_ready(data_ready), .dec_restart(dec_restart),
    .nvm_commit(nvm_commit), .abc_busy(abc_busy),
    .general_line_one_out(l1o), .general_line_one_oe(l1e),
    .general_line_two_out(l2o), .general_line_two_oe(l2e));
  gbau_host host (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .sample(sample));
  // ==========================================================
  // Clock, commit counter and checking
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (nvm_commit === 1'b1) commits++;
  always @(posedge core_clk) if (data_ready === 1'b1) readies++;
  task automatic chk_word(input logic [15:0] x, input logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, x, g);
    end
  endtask
  task automatic chk_flag(input logic [3:0] x, input logic [3:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, x, g);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] x);
    logic [15:0] v;
    host.rd(a, v);
    chk_word(x, v);
  endtask
  task automatic final_report();
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Static alarm: two samples of one value, then status and pins.
  task automatic st(input logic [15:0] cfg, gy, fl,
                    input logic [1:0] es, input logic [3:0] ep);
    logic [3:0] m;
    // Only the driven line has a defined level; enables always count.
    m = {cfg[2] & ~cfg[0], 1'b1, cfg[2] & cfg[0], 1'b1};
    host.wr(7'h18, cfg);
    gyro_raw = {gy, 16'h0000};
    gyro_filt_upper = fl;
    host.smp();
    host.smp();
    repeat (2) @(posedge core_clk);
    host.rd(7'h26, d);
    chk_word({6'h00, es, 8'h00}, d);
    chk_flag(ep & m, pins & m);
  endtask
  // Rate alarm one over three samples with a given lag.
  task automatic roc(input logic [7:0] per, input logic [15:0] v0, v1, v2,
                     input logic x);
    host.wr(7'h14, {8'hff, per});
    gyro_raw = {v0, 16'h0000};
    host.smp();
    gyro_raw = {v1, 16'h0000};
    host.smp();
    gyro_raw = {v2, 16'h0000};
    host.smp();
    repeat (2) @(posedge core_clk);
    host.rd(7'h26, d);
    chk_flag({3'b000, x}, {2'b00, d[9:8]});
  endtask
  task automatic t_regs();
    logic [6:0] rl [8] = '{7'h08, 7'h0a, 7'h10, 7'h12, 7'h14, 7'h16,
                           7'h18, 7'h30};
    foreach (rl[i]) rchk(rl[i], 16'h0000);
    host.wr(7'h10, 16'ha5c3);
    rchk(7'h10, 16'ha5c3);
    host.wr(7'h28, 16'h0000);
    rchk(7'h28, 16'h0000);
  endtask
  task automatic t_bias();
    int r0;
    r0 = readies;
    host.wr(7'h08, 16'hffff);
    host.wr(7'h0a, 16'h0001);
    gyro_raw = 32'h0002_0001;
    host.smp();
    rchk(7'h06, 16'h0004);
    rchk(7'h04, 16'h0000);
    chk_word(16'(r0 + 1), 16'(readies));
  endtask
  task automatic t_abc();
    int c0;
    c0 = commits;
    decimation_setting = 5'h01;
    gyro_raw = 32'h0001_8000;
    e = ~(32'h0001_8000 + 32'h0001_ffff) + 32'h1;
    host.wr(7'h28, 16'h0001);
    @(posedge core_clk);
    chk_flag(4'h1, {3'b000, abc_busy});
    host.wr(7'h10, 16'h5555);
    host.rd(7'h10, d);
    chk_word(16'h0000, d);
    for (int n = 0; n < 200 && abc_busy === 1'b1; n++) host.smp();
    chk_flag(4'h0, {3'b000, abc_busy});
    rchk(7'h0a, e[31:16]);
    rchk(7'h08, e[15:0]);
    rchk(7'h10, 16'ha5c3);
    chk_word(16'(c0 + 1), 16'(commits));
  endtask
  task automatic t_restore();
    int c0;
    c0 = commits;
    host.wr(7'h28, 16'h0002);
    repeat (25) @(posedge core_clk);
    chk_word(16'(c0 + 1), 16'(commits));
    rchk(7'h0a, 16'h0000);
    rchk(7'h08, 16'h0000);
    rchk(7'h10, 16'h0000);
    rchk(7'h06, 16'h0000);
  endtask
  task automatic t_alarms();
    host.wr(7'h10, 16'h0100);
    host.wr(7'h12, 16'h0010);
    temp_word = 16'h0005;
    st(16'h2117, 16'h0200, 16'h0050, 2'b11, 4'b0011);
    st(16'h211f, 16'h0200, 16'h0050, 2'b10, 4'b0011);
    st(16'h2117, 16'hff00, 16'h0050, 2'b10, 4'b0011);
    st(16'h2114, 16'h0200, 16'h0050, 2'b11, 4'b0100);
    st(16'h3000, 16'h0200, 16'h0050, 2'b10, 4'b0000);
    host.wr(7'h10, 16'h0010);
    host.wr(7'h18, 16'h0150);
    roc(8'h02, 16'h0000, 16'h0008, 16'h0016, 1'b1);
    roc(8'h01, 16'h0000, 16'h0008, 16'h0016, 1'b0);
    roc(8'h00, 16'h0000, 16'h0008, 16'h0016, 1'b0);
    roc(8'h00, 16'h0016, 16'h0030, 16'h0010, 1'b1);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    nrst = 1'b0;
    gyro_raw = 32'h0;
    gyro_filt_upper = 16'h0000;
    temp_word = 16'h0000;
    decimation_setting = 5'h00;
    repeat (4) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_regs();
    t_bias();
    t_abc();
    t_restore();
    t_alarms();
    final_report();
  end
  // The whole run needs a few hundred cycles; this is ample margin.
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule // testbench
